// file: common/aab_alu_if.sv
interface aab_alu_if;
    import aab_pkg::*;
    aab_op_t op;
    aab_byte_t acc;
    aab_byte_t lit;
    aab_byte_t operand;
    aab_bit_t bit_idx;
    aab_byte_t result;
    logic carry;
    logic nibble_carry;
    logic bit_val;

    modport core (
        output op, acc, lit, operand, bit_idx,
        input result, carry, nibble_carry, bit_val
    );
    modport alu (
        input op, acc, lit, operand, bit_idx,
        output result, carry, nibble_carry, bit_val
    );
endinterface : aab_alu_if

// file: common/aab_pkg.sv
`include "aab_regs.svh"

package aab_pkg;

    typedef enum logic [2:0] {
        add_literal_to_acc = 3'h0,
        add_acc_with_file_reg = 3'h1,
        and_literal_with_acc = 3'h2,
        and_acc_with_file_reg = 3'h3,
        file_bit_clear_op = 3'h4,
        file_bit_set_op = 3'h5,
        test_skip_if_zero_op = 3'h6,
        test_skip_if_one_op = 3'h7
    } aab_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_EXEC = 2'h1,
        ST_NOP = 2'h2
    } aab_state_t;

    typedef logic [`AAB_DATA_W-1:0] aab_byte_t;
    typedef logic [`AAB_ADDR_W-1:0] aab_addr_t;
    typedef logic [`AAB_BIT_W-1:0] aab_bit_t;

endpackage : aab_pkg

// file: common/aab_regs.svh
`ifndef AAB_REGS_SVH
`define AAB_REGS_SVH

`define AAB_DATA_W 8
`define AAB_ADDR_W 7
`define AAB_BIT_W 3
`define AAB_CARRY_BIT 8
`define AAB_NIBBLE_BIT 4
`define AAB_ACC_RST 8'h00
`define AAB_FLAG_RST 1'b0
`define AAB_DEST_ACC 1'b0
`define AAB_DEST_FILE 1'b1
`define AAB_SKIP_CYCLES 2

`endif

// file: rtl/aab_alu.sv
`include "aab_regs.svh"
module aab_alu (
    aab_alu_if.alu alu
);
    import aab_pkg::*;

    logic [`AAB_DATA_W:0] sum;
    logic [`AAB_NIBBLE_BIT:0] low_sum;
    aab_byte_t src;
    aab_byte_t mask;

    always_comb
    begin
        src = alu.operand;
        if (alu.op == add_literal_to_acc || alu.op == and_literal_with_acc)
        begin
            src = alu.lit;
        end
        sum = {1'b0, alu.acc} + {1'b0, src};
        // carry out of bit 3 taken from the low nibbles alone
        low_sum = {1'b0, alu.acc[`AAB_NIBBLE_BIT-1:0]}
            + {1'b0, src[`AAB_NIBBLE_BIT-1:0]};
        mask = aab_byte_t'(1) << alu.bit_idx;
        alu.carry = sum[`AAB_CARRY_BIT];
        alu.nibble_carry = low_sum[`AAB_NIBBLE_BIT];
        alu.bit_val = src[alu.bit_idx];
        case (alu.op)
            add_literal_to_acc,
            add_acc_with_file_reg: alu.result = sum[`AAB_DATA_W-1:0];
            and_literal_with_acc,
            and_acc_with_file_reg: alu.result = alu.acc & src;
            file_bit_clear_op: alu.result = src & ~mask;
            file_bit_set_op: alu.result = src | mask;
            default: alu.result = src;
        endcase
    end

endmodule : aab_alu

// file: rtl/aab_core.sv
// How it works
// - add literal sums the accumulator with an 8-bit immediate into the accumulator and updates carry, nibble carry and zero.
// - add register sums the accumulator with the file register at a 7-bit address and updates carry, nibble carry and zero.
// - for register add and and, destination 0 writes the accumulator and destination 1 writes the file register.
// - and literal ands the accumulator with an immediate into the accumulator, changing only the zero flag.
// - and register ands the accumulator with the file register, routed by destination, changing only the zero flag.
// - bit clear forces the indexed bit of the file register to zero and leaves all flags alone.
// - bit set forces the indexed bit of the file register to one and leaves all flags alone.
// - test skip if zero lets the next instruction run when the bit is one, else discards it with a one-cycle nop.
// - test skip if one lets the next instruction run when the bit is zero, else discards it with a one-cycle nop.
// - a read-modify-write of an i/o port register takes its operand from the pin levels, not the latch.
// - a taken skip spends a second cycle on the instruction and that cycle does nothing.
`include "aab_regs.svh"
module aab_core (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic op_valid_i,
    input wire aab_pkg::aab_op_t op_code_i,
    input wire aab_pkg::aab_addr_t op_addr_i,
    input wire logic op_dest_i,
    input wire aab_pkg::aab_bit_t op_bit_i,
    input wire aab_pkg::aab_byte_t op_literal_i,
    input wire aab_pkg::aab_byte_t fr_rdata_i,
    input wire logic fr_is_port_i,
    input wire aab_pkg::aab_byte_t pin_level_i,
    output logic op_ready_o,
    output logic op_done_o,
    output logic skip_o,
    output aab_pkg::aab_addr_t fr_addr_o,
    output logic fr_we_o,
    output aab_pkg::aab_byte_t fr_wdata_o,
    output aab_pkg::aab_byte_t acc_o,
    output logic carry_o,
    output logic nibble_carry_flag_o,
    output logic zero_o
);
    import aab_pkg::*;

    typedef struct packed {
        aab_state_t state;
        aab_op_t op;
        logic dest;
        aab_bit_t bit_idx;
        aab_byte_t lit;
        aab_addr_t addr;
        logic ready;
        logic done;
        logic skip;
        logic we;
        aab_byte_t wdata;
        aab_byte_t acc;
        logic carry;
        logic nibble_carry;
        logic zero;
        aab_byte_t pin_meta;
        aab_byte_t pin_sync;
    } aab_core_st_t;

    aab_core_st_t st;
    aab_core_st_t next_st;
    aab_alu_if alu_bus ();

    logic is_reg_op;
    logic to_file;
    logic from_pins;
    logic skip_taken;
    aab_byte_t operand;

    ////////////////////////////////////////////////////////////////////////
    aab_alu u_alu (
        .alu(alu_bus.alu)
    );

    always_comb
    begin
        is_reg_op = st.op == add_acc_with_file_reg
            || st.op == and_acc_with_file_reg;
        to_file = (is_reg_op && st.dest == `AAB_DEST_FILE)
            || st.op == file_bit_clear_op || st.op == file_bit_set_op;
        // latch may disagree with a pin pulled low from outside
        from_pins = fr_is_port_i && to_file;
        operand = from_pins ? st.pin_sync : fr_rdata_i;
        alu_bus.op = st.op;
        alu_bus.acc = st.acc;
        alu_bus.lit = st.lit;
        alu_bus.operand = operand;
        alu_bus.bit_idx = st.bit_idx;
        skip_taken = (st.op == test_skip_if_zero_op && !alu_bus.bit_val)
            || (st.op == test_skip_if_one_op && alu_bus.bit_val);
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_st = st;
        next_st.pin_meta = pin_level_i;
        next_st.pin_sync = st.pin_meta;
        next_st.done = 1'b0;
        next_st.skip = 1'b0;
        next_st.we = 1'b0;
        case (st.state)
            ST_IDLE:
            begin
                if (op_valid_i)
                begin
                    next_st.op = op_code_i;
                    next_st.addr = op_addr_i;
                    next_st.dest = op_dest_i;
                    next_st.bit_idx = op_bit_i;
                    next_st.lit = op_literal_i;
                    next_st.ready = 1'b0;
                    next_st.state = ST_EXEC;
                end
            end
            ST_EXEC:
            begin
                case (st.op)
                    add_literal_to_acc, add_acc_with_file_reg:
                    begin
                        next_st.carry = alu_bus.carry;
                        next_st.nibble_carry = alu_bus.nibble_carry;
                        next_st.zero = alu_bus.result == '0;
                    end
                    and_literal_with_acc, and_acc_with_file_reg:
                    begin
                        next_st.zero = alu_bus.result == '0;
                    end
                    default:
                    begin
                        // bit ops and tests keep every flag
                        next_st.zero = st.zero;
                    end
                endcase
                if (to_file)
                begin
                    next_st.we = 1'b1;
                    next_st.wdata = alu_bus.result;
                end
                else if (st.op inside {add_literal_to_acc,
                    and_literal_with_acc} || is_reg_op)
                begin
                    next_st.acc = alu_bus.result;
                end
                if (skip_taken)
                begin
                    // next fetch is thrown away, so burn a quiet cycle
                    next_st.skip = 1'b1;
                    next_st.state = ST_NOP;
                end
                else
                begin
                    next_st.done = 1'b1;
                    next_st.ready = 1'b1;
                    next_st.state = ST_IDLE;
                end
            end
            ST_NOP:
            begin
                next_st.done = 1'b1;
                next_st.ready = 1'b1;
                next_st.state = ST_IDLE;
            end
            default:
            begin
                next_st.ready = 1'b1;
                next_st.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            st <= '0;
            st.state <= ST_IDLE;
            st.ready <= 1'b1;
            st.acc <= `AAB_ACC_RST;
            st.carry <= `AAB_FLAG_RST;
            st.nibble_carry <= `AAB_FLAG_RST;
            st.zero <= `AAB_FLAG_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign op_ready_o = st.ready;
    assign op_done_o = st.done;
    assign skip_o = st.skip;
    assign fr_addr_o = st.addr;
    assign fr_we_o = st.we;
    assign fr_wdata_o = st.wdata;
    assign acc_o = st.acc;
    assign carry_o = st.carry;
    assign nibble_carry_flag_o = st.nibble_carry;
    assign zero_o = st.zero;

    ////////////////////////////////////////////////////////////////////////
    logic [`AAB_DATA_W:0] chk_sum;
    logic accept;
    logic in_exec;

    assign chk_sum = {1'b0, st.acc} + {1'b0, fr_rdata_i};
    assign accept = op_valid_i && op_ready_o;
    assign in_exec = st.state == ST_EXEC;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);

    property p_add_lit;
        accept && op_code_i == add_literal_to_acc
        |-> ##2 acc_o == 8'($past(acc_o, 2) + $past(op_literal_i, 2));
    endproperty
    a_add_lit: assert property (p_add_lit)
        else $error("add literal result wrong");

    property p_add_reg;
        in_exec && st.op == add_acc_with_file_reg && !fr_is_port_i
        |=> carry_o == $past(chk_sum[`AAB_CARRY_BIT]);
    endproperty
    a_add_reg: assert property (p_add_reg)
        else $error("add register carry wrong");

    property p_dest;
        in_exec && is_reg_op
        |=> (fr_we_o == $past(st.dest))
            && ($past(st.dest) -> acc_o == $past(acc_o));
    endproperty
    a_dest: assert property (p_dest)
        else $error("destination routing wrong");

    property p_and_lit;
        accept && op_code_i == and_literal_with_acc
        |-> ##2 acc_o == ($past(acc_o, 2) & $past(op_literal_i, 2))
            && carry_o == $past(carry_o, 2)
            && nibble_carry_flag_o == $past(nibble_carry_flag_o, 2);
    endproperty
    a_and_lit: assert property (p_and_lit)
        else $error("and literal wrong");

    property p_and_reg;
        in_exec && st.op == and_acc_with_file_reg
        |=> $stable(carry_o) && $stable(nibble_carry_flag_o);
    endproperty
    a_and_reg: assert property (p_and_reg)
        else $error("and register touched carry");

    property p_bit_clear;
        in_exec && st.op == file_bit_clear_op
        |=> fr_we_o && !fr_wdata_o[$past(st.bit_idx)]
            && $stable(zero_o) && $stable(carry_o);
    endproperty
    a_bit_clear: assert property (p_bit_clear)
        else $error("bit clear wrong");

    property p_bit_set;
        in_exec && st.op == file_bit_set_op
        |=> fr_we_o && fr_wdata_o[$past(st.bit_idx)]
            && $stable(zero_o) && $stable(nibble_carry_flag_o);
    endproperty
    a_bit_set: assert property (p_bit_set)
        else $error("bit set wrong");

    property p_skip_zero;
        in_exec && st.op == test_skip_if_zero_op && !fr_rdata_i[st.bit_idx]
        |=> skip_o && !op_done_o ##1 op_done_o;
    endproperty
    a_skip_zero: assert property (p_skip_zero)
        else $error("skip on zero not taken");

    property p_skip_one;
        in_exec && st.op == test_skip_if_one_op && !fr_rdata_i[st.bit_idx]
        |=> op_done_o && !skip_o && $stable(zero_o);
    endproperty
    a_skip_one: assert property (p_skip_one)
        else $error("skip on one taken wrongly");

    property p_port;
        in_exec && st.op == file_bit_set_op && fr_is_port_i
        |=> fr_wdata_o == ($past(st.pin_sync)
            | (aab_byte_t'(1) << $past(st.bit_idx)));
    endproperty
    a_port: assert property (p_port)
        else $error("port operand not from pins");

    property p_nop;
        skip_o |=> !fr_we_o && $stable(acc_o) && op_done_o;
    endproperty
    a_nop: assert property (p_nop)
        else $error("skip cycle not idle");

    property p_zero;
        in_exec && st.op == add_literal_to_acc
        |=> zero_o == (acc_o == '0);
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero flag wrong");

    c_add: cover property (in_exec && st.op == add_acc_with_file_reg);
    c_skip: cover property (skip_o ##1 op_done_o);
    c_port: cover property (in_exec && fr_is_port_i && to_file);
    c_carry: cover property (carry_o && nibble_carry_flag_o);

endmodule : aab_core

// file: tb/aab_fr_model.sv
// file register memory as seen by the core; reads settle combinationally
module aab_fr_model
    import aab_pkg::*;
#(
    parameter aab_pkg::aab_addr_t PORT_ADDR = 7'h06
)
(
    input wire logic core_clk_i,
    input wire aab_pkg::aab_addr_t fr_addr_i,
    input wire logic fr_we_i,
    input wire aab_pkg::aab_byte_t fr_wdata_i,
    output aab_pkg::aab_byte_t fr_rdata_o,
    output logic fr_is_port_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // unwritten cells stay unknown so a stray read shows up
    aab_byte_t mem [0:127];

    assign fr_rdata_o = mem[fr_addr_i];
    assign fr_is_port_o = (fr_addr_i == PORT_ADDR);

    always @(posedge core_clk_i)
    begin
        if (fr_we_i === 1'b1)
            mem[fr_addr_i] <= fr_wdata_i;
    end
endmodule : aab_fr_model

// file: tb/accumulator_alu_bit_ops_tb.sv
module accumulator_alu_bit_ops_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import aab_pkg::*;

    logic core_clk_i, reset_i, op_valid_i, op_dest_i, fr_is_port;
    aab_op_t op_code_i;
    aab_addr_t op_addr_i, fr_addr_o;
    aab_bit_t op_bit_i;
    aab_byte_t op_literal_i, fr_rdata, pin_level_i, fr_wdata_o, acc_o;
    logic op_ready_o, op_done_o, skip_o, fr_we_o;
    logic carry_o, nibble_carry_flag_o, zero_o;
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;
    int cyc, wes;
    logic skp;

    aab_core uut (.core_clk_i(core_clk_i), .reset_i(reset_i),
        .op_valid_i(op_valid_i), .op_code_i(op_code_i),
        .op_addr_i(op_addr_i), .op_dest_i(op_dest_i), .op_bit_i(op_bit_i),
        .op_literal_i(op_literal_i), .fr_rdata_i(fr_rdata),
        .fr_is_port_i(fr_is_port), .pin_level_i(pin_level_i),
        .op_ready_o(op_ready_o), .op_done_o(op_done_o), .skip_o(skip_o),
        .fr_addr_o(fr_addr_o), .fr_we_o(fr_we_o), .fr_wdata_o(fr_wdata_o),
        .acc_o(acc_o), .carry_o(carry_o),
        .nibble_carry_flag_o(nibble_carry_flag_o), .zero_o(zero_o));

    aab_fr_model #(.PORT_ADDR(7'h06)) mem_m (.core_clk_i(core_clk_i),
        .fr_addr_i(fr_addr_o), .fr_we_i(fr_we_o), .fr_wdata_i(fr_wdata_o),
        .fr_rdata_o(fr_rdata), .fr_is_port_o(fr_is_port));

    initial
    begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input aab_byte_t got, input aab_byte_t exp,
                       input string msg);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: %s got %h expected %h", $time, msg,
                     got, exp);
        end
    endtask : chk

    task automatic chk_flags(input logic c, input logic dc, input logic z);
        chk({5'h00, carry_o, nibble_carry_flag_o, zero_o},
            {5'h00, c, dc, z}, "flags");
    endtask : chk_flags

    // one instruction; counts cycles from take to done and write strobes
    task automatic exec(input aab_op_t op, input aab_addr_t a,
                        input logic d, input aab_bit_t b, input aab_byte_t k);
        cyc = 0;
        wes = 0;
        skp = 1'b0;
        @(negedge core_clk_i);
        chk({7'h00, op_ready_o}, 8'h01, "ready before request");
        op_valid_i = 1'b1;
        op_code_i = op;
        op_addr_i = a;
        op_dest_i = d;
        op_bit_i = b;
        op_literal_i = k;
        while (op_done_o !== 1'b1 && cyc < 6)
        begin
            @(negedge core_clk_i);
            op_valid_i = 1'b0;
            cyc++;
            if (skip_o === 1'b1)
                skp = 1'b1;
            if (fr_we_o === 1'b1)
                wes++;
        end
        // the file write lands on the edge after its strobe
        @(negedge core_clk_i);
    endtask : exec

    ////////////////////////////////////////////////////////////////////////
    task automatic test_add_lit;
        exec(add_literal_to_acc, 7'h10, 1'b0, 3'h0, 8'h8F);
        chk(acc_o, 8'h8F, "add lit acc");
        chk_flags(1'b0, 1'b0, 1'b0);
        exec(add_literal_to_acc, 7'h10, 1'b1, 3'h0, 8'h71);
        chk(acc_o, 8'h00, "add lit wrap");
        chk_flags(1'b1, 1'b1, 1'b1);
        chk(cyc[7:0], 8'h02, "add lit cycles");
        chk(wes[7:0], 8'h00, "add lit no write");
        $display("test add literal done");
    endtask : test_add_lit

    task automatic test_add_reg;
        mem_m.mem[7'h7F] = 8'h08;
        mem_m.mem[7'h00] = 8'hF0;
        exec(add_literal_to_acc, 7'h00, 1'b0, 3'h0, 8'h08);
        exec(add_acc_with_file_reg, 7'h7F, 1'b0, 3'h0, 8'h00);
        chk(acc_o, 8'h10, "add reg to acc");
        chk_flags(1'b0, 1'b1, 1'b0);
        chk(wes[7:0], 8'h00, "dest acc no write");
        exec(add_acc_with_file_reg, 7'h00, 1'b1, 3'h0, 8'h00);
        chk(mem_m.mem[7'h00], 8'h00, "add reg to file");
        chk(acc_o, 8'h10, "acc kept");
        chk_flags(1'b1, 1'b0, 1'b1);
        chk(wes[7:0], 8'h01, "one write strobe");
        chk({1'b0, fr_addr_o}, 8'h00, "file address");
        $display("test add register done");
    endtask : test_add_reg

    task automatic test_and;
        mem_m.mem[7'h01] = 8'h01;
        mem_m.mem[7'h02] = 8'h1F;
        exec(and_literal_with_acc, 7'h00, 1'b0, 3'h0, 8'h30);
        chk(acc_o, 8'h10, "and lit");
        chk_flags(1'b1, 1'b0, 1'b0);
        exec(and_acc_with_file_reg, 7'h01, 1'b1, 3'h0, 8'h00);
        chk(mem_m.mem[7'h01], 8'h00, "and reg to file");
        chk(acc_o, 8'h10, "acc kept");
        chk_flags(1'b1, 1'b0, 1'b1);
        exec(and_acc_with_file_reg, 7'h02, 1'b0, 3'h0, 8'h00);
        chk(acc_o, 8'h10, "and reg to acc");
        chk_flags(1'b1, 1'b0, 1'b0);
        $display("test and done");
    endtask : test_and

    task automatic test_bits;
        aab_byte_t exp;
        exp = 8'h00;
        mem_m.mem[7'h03] = 8'h00;
        for (int i = 0; i < 16; i++)
        begin
            if (i < 8)
                exp = exp | (8'h01 << i);
            else
                exp = exp & ~(8'h01 << (i - 8));
            exec((i < 8) ? file_bit_set_op : file_bit_clear_op, 7'h03, 1'b0,
                 aab_bit_t'(i), 8'h00);
            chk(mem_m.mem[7'h03], exp, "bit op result");
            chk_flags(1'b1, 1'b0, 1'b0);
        end
        $display("test bit set clear done");
    endtask : test_bits

    task automatic test_port;
        // latch reads all ones but the pins pull the upper half low
        mem_m.mem[7'h06] = 8'hFF;
        exec(file_bit_set_op, 7'h06, 1'b0, 3'h7, 8'h00);
        chk(mem_m.mem[7'h06], 8'h8F, "port uses pins");
        chk(fr_wdata_o, 8'h8F, "port write data");
        chk({1'b0, fr_addr_o}, 8'h06, "port address");
        $display("test port read modify write done");
    endtask : test_port

    task automatic test_skip;
        aab_op_t op;
        logic exp;
        mem_m.mem[7'h04] = 8'h5A;
        for (int i = 0; i < 4; i++)
        begin
            op = (i < 2) ? test_skip_if_zero_op : test_skip_if_one_op;
            exp = (i < 2) ? (i == 0) : (i == 3);
            exec(op, 7'h04, 1'b0, aab_bit_t'(i % 2), 8'h00);
            chk({7'h00, skp}, {7'h00, exp}, "skip");
            chk(cyc[7:0], exp ? 8'h03 : 8'h02, "skip cycles");
            chk(wes[7:0], 8'h00, "test no write");
            chk_flags(1'b1, 1'b0, 1'b0);
            chk(acc_o, 8'h10, "test acc kept");
        end
        $display("test skip done");
    endtask : test_skip

    ////////////////////////////////////////////////////////////////////////
    task automatic results;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results

    // whole run needs about 130 cycles
    always @(posedge core_clk_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            $display("Error at %0t: run timed out", $time);
            results();
        end
    end

    initial
    begin
        reset_i = 1'b1;
        op_valid_i = 1'b0;
        op_code_i = add_literal_to_acc;
        op_addr_i = 7'h00;
        op_dest_i = 1'b0;
        op_bit_i = 3'h0;
        op_literal_i = 8'h00;
        pin_level_i = 8'h0F;
        repeat (8) @(negedge core_clk_i);
        reset_i = 1'b0;
        chk(acc_o, 8'h00, "reset acc");
        chk_flags(1'b0, 1'b0, 1'b0);
        test_add_lit();
        test_add_reg();
        test_and();
        test_bits();
        test_port();
        test_skip();
        results();
    end
endmodule : accumulator_alu_bit_ops_tb
